// ===== logic/sktsq_top.sv
/*
  Burst sequencer and signal processing for one capacitive key.
  Assumes an analog front end that runs a burst on burst_start and
  returns the count on burst_value with burst_done; select is a pin.
*/
`timescale 1ns/1ns
`default_nettype none
module sktsq_top
  import sktsq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // mode-select pin
  input wire logic select,
  // measurement front end
  output logic burst_start,
  input wire logic burst_done,
  input wire logic [11:0] burst_value,
  output logic [3:0] osc_trim,
  // touch output pin
  output logic touch_out,
  output logic touch_oe,
  // status
  output logic [1:0] run_mode
);
  import sktsq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchroniser
  logic rst_a_reg, rst_b_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_a_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_b_reg <= rst_a_reg;
    end
  end
  wire logic rst_sync_n = rst_b_reg;

  // select chain resets to the fast-mode level; no sleep state is live then
  // sel_c only delays sel_b to find edges, nothing else reads sel_a
  logic sel_a_reg, sel_b_reg, sel_c_reg;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sel_a_reg <= 1'b1;
      sel_b_reg <= 1'b1;
      sel_c_reg <= 1'b1;
    end else begin
      sel_a_reg <= select;
      sel_b_reg <= sel_a_reg;
      sel_c_reg <= sel_b_reg;
    end
  end
  wire logic sel_fall = sel_c_reg & ~sel_b_reg;
  wire logic sel_edge = sel_c_reg ^ sel_b_reg;

  ////////////////////////////////////////////////////////////////////////
  // sequencer and processing state
  sktsq_state_type state_reg, state_next;
  sktsq_mode_type mode_reg, mode_next;
  logic [GAP_W-1:0] gap_reg, gap_next;
  logic [GAP_W-1:0] idle_reg, idle_next;
  logic [11:0] ref_reg, ref_next;
  logic [2:0] conf_reg, conf_next;
  logic detect_reg, detect_next;
  logic [ONCNT_W-1:0] on_reg, on_next;
  logic [3:0] drift_reg, drift_next;
  logic [3:0] trim_reg, trim_next;
  logic start_reg, start_next;
  logic oe_reg, oe_next;
  logic recal_reg, recal_next;

  function automatic logic [11:0] delta_up(input logic [11:0] sig, input logic [11:0] rf);
    delta_up = (sig > rf) ? 12'(sig - rf) : 12'h000;
  endfunction : delta_up

  function automatic logic is_sync(input sktsq_mode_type m);
    is_sync = (m == SKTSQ_SYNC);
  endfunction : is_sync

  function automatic logic in_burst(input sktsq_state_type s);
    in_burst = (s == SKTSQ_BURST);
  endfunction : in_burst

  function automatic logic [GAP_W-1:0] spacing(input sktsq_mode_type m, input logic busy);
    spacing = (m == SKTSQ_LOWPWR && !busy) ? GAP_W'(LP_GAP_CYC) : GAP_W'(FAST_GAP_CYC);
  endfunction : spacing

  ////////////////////////////////////////////////////////////////////////
  // events shared by the processing groups
  logic hit;
  logic done_now;
  logic on_expire;
  logic recal_now;
  logic [11:0] delta;
  always_comb begin
    // delta is zero when the signal sits below the reference
    delta = delta_up(burst_value, ref_reg);
    hit = detect_reg ? (delta >= 12'(THRESHOLD - HYSTERESIS)) : (delta >= THRESHOLD);
    // answers outside a burst are ignored
    done_now = in_burst(state_reg) && burst_done;
    // on-duration runs out on this burst
    on_expire = detect_reg && hit && (on_reg + 1'b1 >= ONCNT_W'(ON_MAX_BURSTS));
    // only power-up or timeout recalibrates; recal_reg is the power-up case
    recal_now = done_now && (recal_reg || on_expire);
  end

  ////////////////////////////////////////////////////////////////////////
  // burst sequencer
  logic pending;
  logic [GAP_W-1:0] gap_len;
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    gap_next = gap_reg;
    idle_next = idle_reg;
    start_next = 1'b0;
    oe_next = 1'b1;
    // confirmation in progress uses fast spacing
    pending = (conf_reg != 3'h0) && !detect_reg;
    gap_len = spacing(mode_reg, pending);
    unique case (state_reg)
      SKTSQ_CAL: begin
        start_next = 1'b1;
        state_next = SKTSQ_BURST;
      end
      SKTSQ_GAP: begin
        gap_next = gap_reg + 1'b1;
        if (gap_reg + 1'b1 >= gap_len) begin
          gap_next = '0;
          // alive pulse ahead of slow bursts
          if (mode_reg == SKTSQ_LOWPWR) begin
            state_next = SKTSQ_ALIVE;
          end else begin
            start_next = 1'b1;
            state_next = SKTSQ_BURST;
          end
        end
      end
      SKTSQ_SLEEP: begin
        // unchanged select too long leaves sync mode
        idle_next = sel_edge ? '0 : idle_reg + 1'b1;
        if (sel_fall) begin
          idle_next = '0;
          state_next = SKTSQ_ALIVE;
        end else if (idle_reg >= GAP_W'(SYNC_TMO_CYC)) begin
          idle_next = '0;
          mode_next = sel_b_reg ? SKTSQ_FAST : SKTSQ_LOWPWR;
          state_next = sel_b_reg ? SKTSQ_GAP : SKTSQ_ALIVE;
        end
      end
      SKTSQ_ALIVE: begin
        // release the output for the alive pulse
        oe_next = 1'b0;
        gap_next = gap_reg + 1'b1;
        // count runs one past the pulse so the pin is released a full width
        if (gap_reg >= GAP_W'(ALIVE_CYC)) begin
          gap_next = '0;
          oe_next = 1'b1;
          start_next = 1'b1;
          state_next = SKTSQ_BURST;
        end
      end
      SKTSQ_BURST: begin
        // the answer closes the burst; processing runs in its own groups
        if (burst_done) begin
          gap_next = '0;
          idle_next = '0;
          if (is_sync(mode_reg)) begin
            state_next = SKTSQ_SLEEP;
          end else if (sel_b_reg) begin
            mode_next = SKTSQ_FAST;
            state_next = SKTSQ_GAP;
          end else if (mode_reg == SKTSQ_FAST) begin
            // low sample in fast mode sleeps into sync mode
            mode_next = SKTSQ_SYNC;
            state_next = SKTSQ_SLEEP;
          end else begin
            // low power stays low power while select is low
            state_next = SKTSQ_GAP;
          end
        end
      end
      default: begin
        state_next = SKTSQ_CAL;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= SKTSQ_CAL;
      mode_reg <= SKTSQ_FAST;
      gap_reg <= '0;
      idle_reg <= '0;
      start_reg <= 1'b0;
      oe_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      gap_reg <= gap_next;
      idle_reg <= idle_next;
      start_reg <= start_next;
      oe_reg <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // confirmation and detection
  always_comb begin
    conf_next = conf_reg;
    detect_next = detect_reg;
    recal_next = recal_reg;
    // a hit while already detecting only feeds the on-duration timer
    if (recal_now) begin
      conf_next = 3'h0;
      detect_next = 1'b0;
      recal_next = 1'b0;
    end else if (done_now && hit && !detect_reg) begin
      if (is_sync(mode_reg)) begin
        detect_next = 1'b1;
      end else begin
        conf_next = conf_reg + 3'h1;
        if (conf_reg + 3'h1 >= CONFIRM_COUNT) begin
          detect_next = 1'b1;
          conf_next = 3'h0;
        end
      end
    end else if (done_now && !hit) begin
      conf_next = 3'h0;
      detect_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      conf_reg <= 3'h0;
      detect_reg <= 1'b0;
      recal_reg <= 1'b1;
    end else begin
      conf_reg <= conf_next;
      detect_reg <= detect_next;
      recal_reg <= recal_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // on-duration timer
  always_comb begin
    on_next = on_reg;
    // cleared by any quiet burst so each detection is timed afresh
    if (recal_now) begin
      on_next = '0;
    end else if (done_now && hit && detect_reg) begin
      on_next = on_reg + 1'b1;
    end else if (done_now && !hit) begin
      on_next = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      on_reg <= '0;
    end else begin
      on_reg <= on_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference tracking
  always_comb begin
    ref_next = ref_reg;
    drift_next = drift_reg;
    if (recal_now) begin
      // reference reloaded from the current signal
      ref_next = burst_value;
    end else if (done_now && !hit) begin
      drift_next = drift_reg + 4'h1;
      // down steps every quiet burst so a removed obstruction recovers fast
      if (burst_value < ref_reg) begin
        ref_next = (12'(ref_reg - burst_value) > STEP_DOWN) ?
                   12'(ref_reg - STEP_DOWN) : burst_value;
      end else if (drift_reg + 4'h1 >= DRIFT_DIV) begin
        // up steps rarely so an approaching finger is not absorbed
        drift_next = 4'h0;
        if (burst_value > ref_reg) begin
          ref_next = 12'(ref_reg + STEP_UP);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_reg <= REF_RESET;
      drift_reg <= 4'h0;
    end else begin
      ref_reg <= ref_next;
      drift_reg <= drift_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // spread-spectrum trim
  always_comb begin
    // centre outside bursts; the front end maps each step onto its range
    trim_next = 4'h8;
    // step oscillator trim through the spread range
    if (in_burst(state_reg) && !burst_done) begin
      trim_next = (trim_reg == SPREAD_STEPS) ? 4'h0 : trim_reg + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trim_reg <= 4'h8;
    end else begin
      trim_reg <= trim_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign burst_start = start_reg;
  assign osc_trim = trim_reg;
  assign touch_out = detect_reg;
  assign touch_oe = oe_reg;
  assign run_mode = mode_reg;
endmodule : sktsq_top
`default_nettype wire

// ===== logic/sktsq_pkg.sv
/*
  Constants and state encodings for the single-key touch sequencer.
  Assumes a 100 MHz clock; times are converted to cycle counts here.
*/
// What this block does
// - mode-select high: fast mode, about 1 ms between bursts.
// - mode-select low: low power mode, about 85 ms sleep after each burst.
// - low power uses fast spacing while a possible touch is being confirmed.
// - mode-select sampled at burst end; low in fast mode enters synchronised mode.
// - synchronised mode: burst only on each falling edge; pulses exceed 10 us.
// - mode-select unchanged over 85 ms in synchronised mode: leave, follow level.
// - synchronised mode bypasses confirmation: one detecting burst is a detection.
// - recalibration timeout counted in bursts, not time.
// - detection when signal exceeds reference by 13 counts.
// - release hysteresis two counts below threshold while detecting.
// - continuous detection timed in bursts; about 80 s at fast spacing forces full recalibration.
// - confirmation counter counts detecting bursts to four; miss clears it.
// - no recalibration input; recalibrate only at power-up or timeout.
// - reference tracks signal slew-limited only while not detecting.
// - reference follows falling signal faster than rising signal.
// - oscillator varied plus or minus 7.5 percent during each burst.
// - output high while detection confirmed; timeout recalibrates and drops it.
// - low power and sync modes: output high impedance 15 us before each burst.
package sktsq_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FAST_GAP_US = 1000;
  localparam int unsigned LP_GAP_US = 85000;
  localparam int unsigned SYNC_TMO_US = 85000;
  localparam int unsigned ALIVE_US = 15;
  localparam int unsigned ON_MAX_MS = 80000;
  localparam int unsigned FAST_GAP_CYC = FAST_GAP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LP_GAP_CYC = LP_GAP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SYNC_TMO_CYC = SYNC_TMO_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ALIVE_CYC = ALIVE_US * (CLK_HZ / 1_000_000);
  // max on-duration in bursts at fast spacing
  localparam int unsigned ON_MAX_BURSTS = ON_MAX_MS / (FAST_GAP_US / 1000);
  localparam logic [11:0] THRESHOLD = 12'h00d;
  localparam logic [11:0] HYSTERESIS = 12'h002;
  localparam logic [2:0] CONFIRM_COUNT = 3'h4;
  localparam logic [11:0] STEP_DOWN = 12'h004;
  localparam logic [11:0] STEP_UP = 12'h001;
  localparam logic [3:0] DRIFT_DIV = 4'h8;
  localparam logic [7:0] SPREAD_PCT_X10 = 8'h4b;
  localparam logic [3:0] SPREAD_STEPS = 4'hf;
  localparam int unsigned GAP_W = 24;
  localparam int unsigned ONCNT_W = 17;
  localparam logic [11:0] REF_RESET = 12'h000;
  typedef enum logic [2:0] {
    SKTSQ_CAL = 3'b000,
    SKTSQ_GAP = 3'b001,
    SKTSQ_ALIVE = 3'b010,
    SKTSQ_BURST = 3'b011,
    SKTSQ_SLEEP = 3'b100
  } sktsq_state_type;
  typedef enum logic [1:0] {
    SKTSQ_FAST = 2'b00,
    SKTSQ_LOWPWR = 2'b01,
    SKTSQ_SYNC = 2'b10
  } sktsq_mode_type;
endpackage : sktsq_pkg

// ===== tb/sktsq_front_model.sv
/*
  Front end model: answers each burst_start with burst_done and a count.
  Assumes the bench sets meas_value before the burst starts.
*/
`timescale 1ns/1ns
`default_nettype none
module sktsq_front_model #(parameter int LAT = 20) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // burst handshake
  input wire logic burst_start,
  output logic burst_done,
  output logic [11:0] burst_value,
  // count to return
  input wire logic [11:0] meas_value
);
  int cnt;
  logic [11:0] last;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      burst_done <= 1'b0;
      burst_value <= 12'h000;
      last <= 12'h000;
    end else begin
      burst_done <= 1'b0;
      // value released after the strobe, never left stale
      burst_value <= ~last;
      if (burst_start) cnt <= LAT;
      else if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1) begin
        burst_done <= 1'b1;
        burst_value <= meas_value;
        last <= meas_value;
      end
    end
  end
endmodule : sktsq_front_model
`default_nettype wire

// ===== tb/sktsq_top_assertions.sv
/*
  Checker for the touch sequencer ports.
  Assumes one clock domain and the package constants.
*/
`timescale 1ns/1ns
`default_nettype none
module sktsq_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pins and front end
  input wire logic select,
  input wire logic burst_start,
  input wire logic burst_done,
  input wire logic [11:0] burst_value,
  input wire logic [3:0] osc_trim,
  input wire logic touch_out,
  input wire logic touch_oe,
  input wire logic [1:0] run_mode
);
  import sktsq_pkg::*;
  logic [23:0] gap_reg, gap_next;
  logic [11:0] lo_reg, lo_next;
  logic busy_reg, busy_next;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_comb begin
    gap_next = burst_done ? 24'h000000 : gap_reg + 24'(gap_reg < 24'(FAST_GAP_CYC));
    lo_next = touch_oe ? 12'h000 : lo_reg + 12'h001;
    busy_next = burst_start | (busy_reg & ~burst_done);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 24'(FAST_GAP_CYC);
      lo_reg <= 12'h000;
      busy_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      lo_reg <= lo_next;
      busy_reg <= busy_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence alive_end;
    $rose(touch_oe);
  endsequence
  sequence start_soon;
    1'b1 ##[0:3] burst_start;
  endsequence
  chk_start_one_cycle: assert property (burst_start |=> !burst_start)
    else $error("burst_start longer than one cycle");
  chk_burst_gap_min: assert property (burst_start && run_mode != SKTSQ_SYNC |->
    gap_reg >= 24'(FAST_GAP_CYC)) else $error("burst gap too short");
  chk_alive_width: assert property (alive_end |-> lo_reg == 12'(ALIVE_CYC))
    else $error("alive pulse width wrong");
  chk_alive_mode_ok: assert property ($fell(touch_oe) |-> run_mode != SKTSQ_FAST)
    else $error("alive pulse in fast mode");
  chk_alive_then_burst: assert property (alive_end |-> start_soon)
    else $error("no burst after alive pulse");
  chk_trim_idle_centre: assert property ((!busy_reg && !burst_start)[*3] |->
    osc_trim == 4'h8) else $error("trim off centre outside burst");
  chk_trim_burst_moves: assert property (busy_reg[*4] |-> $changed(osc_trim))
    else $error("trim still during burst");
  chk_touch_after_burst: assert property ($changed(touch_out) |->
    $past(burst_done) || $past(burst_done, 2)) else $error("touch change without burst");
endmodule : sktsq_assertions
bind sktsq_top sktsq_assertions u_chk (.clock(clock), .rst_n(rst_n), .select(select),
  .burst_start(burst_start), .burst_done(burst_done), .burst_value(burst_value),
  .osc_trim(osc_trim), .touch_out(touch_out), .touch_oe(touch_oe), .run_mode(run_mode));
`default_nettype wire

// ===== tb/single_key_touch_sequencer_tb_top.sv
/*
  Bench: reset, entry to synchronised mode, threshold, hysteresis, drift.
  Assumes the front end model and a host driving select.
*/
`timescale 1ns/1ns
`default_nettype none
module single_key_touch_sequencer_tb_top;
  import sktsq_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic select = 1'b0;
  logic [11:0] meas = 12'h064;
  logic burst_start, burst_done, touch_out, touch_oe;
  logic [11:0] burst_value;
  logic [3:0] osc_trim;
  logic [1:0] run_mode;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 clock = ~clock;
  sktsq_top uut (.clock(clock), .rst_n(rst_n), .select(select), .burst_start(burst_start),
    .burst_done(burst_done), .burst_value(burst_value), .osc_trim(osc_trim),
    .touch_out(touch_out), .touch_oe(touch_oe), .run_mode(run_mode));
  sktsq_front_model fe (.clock(clock), .rst_n(rst_n), .burst_start(burst_start),
    .burst_done(burst_done), .burst_value(burst_value), .meas_value(meas));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // pulse over 10 us, burst on falling edge
  task automatic sync_burst(input logic [11:0] v, input logic exp);
    int lo;
    int n;
    lo = 0;
    meas = v;
    select = 1'b1;
    repeat (1100) @(negedge clock);
    select = 1'b0;
    for (n = 0; n < 3000 && burst_start !== 1'b1; n++) begin
      @(negedge clock);
      if (touch_oe === 1'b0) lo++;
    end
    check(16'(lo), 16'(ALIVE_CYC));
    for (n = 0; n < 200 && burst_done !== 1'b1; n++) @(negedge clock);
    repeat (3) @(negedge clock);
    check(16'(touch_out), 16'(exp));
    check(16'(run_mode), 16'(SKTSQ_SYNC));
  endtask : sync_burst
  task automatic test_reset();
    int n;
    repeat (8) @(negedge clock);
    check(16'({touch_out, touch_oe, burst_start, osc_trim, run_mode}), 16'h00a0);
    rst_n = 1'b1;
    // select held low over the calibration burst
    for (n = 0; n < 100 && burst_done !== 1'b1; n++) @(negedge clock);
    repeat (3) @(negedge clock);
    check(16'(run_mode), 16'(SKTSQ_SYNC));
    check(16'(touch_out), 16'h0000);
    $display("test reset done");
  endtask : test_reset
  task automatic test_threshold();
    sync_burst(12'h070, 1'b0);
    sync_burst(12'h071, 1'b1);
    $display("test threshold done");
  endtask : test_threshold
  task automatic test_hysteresis();
    sync_burst(12'h06f, 1'b1);
    sync_burst(12'h06e, 1'b0);
    $display("test hysteresis done");
  endtask : test_hysteresis
  task automatic test_drift();
    sync_burst(12'h060, 1'b0);
    sync_burst(12'h06d, 1'b1);
    sync_burst(12'h064, 1'b0);
    $display("test drift done");
  endtask : test_drift
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    test_reset();
    test_threshold();
    test_hysteresis();
    test_drift();
    report_and_stop();
  end
endmodule : single_key_touch_sequencer_tb_top
`default_nettype wire
